// ---- rtl/nvw_pkg.sv ----
// Purpose: constants for the non-volatile word memory host controller
// Assumes: 50 MHz reference clock, 20 ns period
// Notes: all times held in their own unit, cycle counts derived here
package nvw_pkg;
	localparam int CLK_MHZ = 50;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 4;
	// operation codes on the command port
	localparam logic [1:0] OP_READ = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_ERASE = 2'h2;
	localparam logic [1:0] OP_FAST = 2'h3;
	// erased word reads all ones
	localparam logic [3:0] ERASED_WORD = 4'hF;
	// times in their printed units
	localparam int T_ERASE_MS = 10;
	localparam int T_WRITE_MS = 10;
	localparam int T_FAST_ERASE_US = 25;
	localparam int T_SETUP_US = 8; // covers 7.5 us select and address set-up
	localparam int T_STROBE_US = 5;
	localparam int T_OUT_US = 3; // covers 2.5 us output delay
	// derived cycle counts, least times rounded up
	localparam int CYC_ERASE = T_ERASE_MS * 1000 * CLK_MHZ;
	localparam int CYC_WRITE = T_WRITE_MS * 1000 * CLK_MHZ;
	localparam int CYC_FAST = T_FAST_ERASE_US * CLK_MHZ;
	localparam int CYC_SETUP = T_SETUP_US * CLK_MHZ;
	localparam int CYC_STROBE = T_STROBE_US * CLK_MHZ;
	localparam int CYC_OUT = T_OUT_US * CLK_MHZ;
	localparam int CNT_W = 20;
endpackage

// ---- rtl/nvw_sync.sv ----
// Purpose: three flop synchroniser for data pins with agreement filter
// Assumes: asynchronous pin inputs
// Notes: a change is taken once second and third stages agree
`timescale 1ns/10ps
module nvw_sync (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic [3:0] d_i,
	output logic [3:0] q_o
);
	typedef struct packed {
		logic [3:0] s1;
		logic [3:0] s2;
		logic [3:0] s3;
		logic [3:0] q;
	} nvw_sync_s;
	nvw_sync_s st_r;
	nvw_sync_s st_nxt;
	// first stage only feeds the second
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = d_i;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		if (st_r.s2 == st_r.s3) begin
			st_nxt.q = st_r.s3;
		end
	end
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign q_o = st_r.q;
endmodule

// ---- rtl/nvw_host.sv ----
// Purpose: host sequencer driving a 64x4 non-volatile word memory
// Assumes: 50 MHz clock, memory pins wired directly, data bus three-state
// Notes: one command at a time; long counts are module parameters
// Function
// - erase-only drops direction, raises strobe, ends after 10 ms via selects high
// - after select-ended erase, strobe goes low, then direction goes high
// - pre-erased reprogramming may shorten the erase strobe, never below 25 us
// - pre-erasing words ahead allows faster later updates
`timescale 1ns/10ps
module nvw_host #(
	parameter int CYC_ERASE = nvw_pkg::CYC_ERASE,
	parameter int CYC_WRITE = nvw_pkg::CYC_WRITE
) (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic cmd_valid_i,
	input wire logic [1:0] cmd_op_i,
	input wire logic [5:0] cmd_addr_i,
	input wire logic [3:0] cmd_data_i,
	output logic cmd_ready_o,
	output logic rsp_valid_o,
	output logic [3:0] rsp_data_o,
	output logic select_in_a_n_o,
	output logic select_in_b_n_o,
	output logic direction_line_o,
	output logic strobe_o,
	output logic [5:0] addr_o,
	input wire logic [3:0] data_i,
	output logic [3:0] data_o,
	output logic data_oe_o
);
	typedef enum {
		S_IDLE, S_SETUP, S_RD_STB, S_RD_OUT, S_EW_FALL, S_EW_ERASE, S_EW_WRITE,
		S_EO_ERASE, S_EO_DESEL, S_EO_DIR
	} nvw_state_e;
	typedef struct packed {
		nvw_state_e st;
		logic [1:0] op;
		logic [19:0] cnt;
		logic sel_n;
		logic dir;
		logic stb;
		logic [5:0] addr;
		logic [3:0] wdata;
		logic oe;
		logic rsp;
		logic [3:0] rdata;
		logic [19:0] run; // cycles the direction and strobe levels have held
	} nvw_host_s;
	nvw_host_s st_r;
	nvw_host_s st_nxt;
	logic [3:0] din_sync;
	logic cnt_done;

	nvw_sync u_sync (
		.ref_clk_i(ref_clk_i),
		.rstn_i(rstn_i),
		.d_i(data_i),
		.q_o(din_sync)
	);

	// counter loader shared by every timed phase
	function automatic logic [19:0] cyc(input int n);
		cyc = 20'(n - 1);
	endfunction

	assign cnt_done = (st_r.cnt == 20'h00000);

	// sequencer: one timed phase per state, count down to zero
	always_comb begin
		st_nxt = st_r;
		st_nxt.rsp = 1'b0;
		if (!cnt_done) begin
			st_nxt.cnt = st_r.cnt - 20'h00001;
		end
		unique case (st_r.st)
			S_IDLE: begin
				// standby: direction high, strobe low; selects low after read or write, high after reset or erase-only
				if (cmd_valid_i) begin
					st_nxt.op = cmd_op_i;
					st_nxt.addr = cmd_addr_i;
					st_nxt.wdata = cmd_data_i;
					st_nxt.sel_n = 1'b0;
					st_nxt.cnt = cyc(nvw_pkg::CYC_SETUP);
					st_nxt.st = S_SETUP;
				end
			end
			S_SETUP: begin
				if (cnt_done) begin
					if (st_r.op == nvw_pkg::OP_READ) begin
						st_nxt.stb = 1'b1; // rising strobe latches word
						st_nxt.cnt = cyc(nvw_pkg::CYC_STROBE);
						st_nxt.st = S_RD_STB;
					end else begin
						st_nxt.dir = 1'b0; // falling direction starts cycle
						st_nxt.cnt = cyc(nvw_pkg::CYC_SETUP);
						st_nxt.st = S_EW_FALL;
					end
				end
			end
			S_RD_STB: begin
				if (cnt_done) begin
					st_nxt.stb = 1'b0; // word appears after strobe falls
					st_nxt.cnt = cyc(nvw_pkg::CYC_OUT + 3);
					st_nxt.st = S_RD_OUT;
				end
			end
			S_RD_OUT: begin
				if (cnt_done) begin
					st_nxt.rdata = din_sync;
					st_nxt.rsp = 1'b1;
					st_nxt.st = S_IDLE; // memory keeps driving word
				end
			end
			S_EW_FALL: begin
				if (cnt_done) begin
					st_nxt.stb = 1'b1; // strobe high erases
					if (st_r.op == nvw_pkg::OP_FAST) begin
						st_nxt.cnt = cyc(nvw_pkg::CYC_FAST); // never below 25 us
					end else begin
						st_nxt.cnt = cyc(CYC_ERASE);
					end
					if (st_r.op == nvw_pkg::OP_ERASE) begin
						st_nxt.st = S_EO_ERASE;
					end else begin
						st_nxt.oe = 1'b1; // drive write data during erase for set-up
						st_nxt.st = S_EW_ERASE;
					end
				end
			end
			S_EW_ERASE: begin
				if (cnt_done) begin
					st_nxt.stb = 1'b0; // falling strobe latches bus data
					st_nxt.cnt = cyc(CYC_WRITE);
					st_nxt.st = S_EW_WRITE;
				end
			end
			S_EW_WRITE: begin
				if (cnt_done) begin
					st_nxt.dir = 1'b1; // rising direction ends write
					st_nxt.oe = 1'b0;
					st_nxt.rdata = st_r.wdata;
					st_nxt.rsp = 1'b1;
					st_nxt.st = S_IDLE;
				end
			end
			S_EO_ERASE: begin
				if (cnt_done) begin
					st_nxt.sel_n = 1'b1; // selects high end erase
					st_nxt.cnt = cyc(nvw_pkg::CYC_STROBE);
					st_nxt.st = S_EO_DESEL;
				end
			end
			S_EO_DESEL: begin
				if (cnt_done) begin
					st_nxt.stb = 1'b0; // strobe low first
					st_nxt.cnt = cyc(nvw_pkg::CYC_STROBE);
					st_nxt.st = S_EO_DIR;
				end
			end
			S_EO_DIR: begin
				if (cnt_done) begin
					st_nxt.dir = 1'b1; // direction high afterwards
					st_nxt.rdata = nvw_pkg::ERASED_WORD; // erased word is all ones
					st_nxt.rsp = 1'b1;
					st_nxt.st = S_IDLE;
				end
			end
		endcase
		// run length of pin levels, saturating so a long idle cannot wrap into a false pass
		if (st_nxt.stb != st_r.stb || st_nxt.dir != st_r.dir) begin
			st_nxt.run = 20'h00000;
		end else if (st_r.run != 20'hFFFFF) begin
			st_nxt.run = st_r.run + 20'h00001;
		end
	end

	// state register, standby pin levels after reset
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			st_r <= '{st: S_IDLE, op: 2'h0, cnt: 20'h00000, sel_n: 1'b1, dir: 1'b1,
				stb: 1'b0, addr: 6'h00, wdata: 4'h0, oe: 1'b0, rsp: 1'b0, rdata: 4'h0,
				run: 20'h00000};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign cmd_ready_o = (st_r.st == S_IDLE);
	assign rsp_valid_o = st_r.rsp;
	assign rsp_data_o = st_r.rdata;
	assign select_in_a_n_o = st_r.sel_n;
	assign select_in_b_n_o = st_r.sel_n;
	assign direction_line_o = st_r.dir;
	assign strobe_o = st_r.stb;
	assign addr_o = st_r.addr;
	assign data_o = st_r.wdata;
	assign data_oe_o = st_r.oe;

	// erase-only: selects rise before strobe falls, strobe falls before direction
	a_eo_order: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		$fell(strobe_o) && st_r.op == nvw_pkg::OP_ERASE |-> select_in_a_n_o && !direction_line_o)
		else $error("erase-only strobe fell in wrong order");
	a_dir_ends: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		$rose(direction_line_o) && st_r.op == nvw_pkg::OP_ERASE |-> select_in_a_n_o && !strobe_o)
		else $error("erase-only direction rose too early");
	a_fast_min: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		$fell(strobe_o) && st_r.op == nvw_pkg::OP_FAST
		|-> $past(st_r.run) >= 20'(nvw_pkg::CYC_FAST - 1))
		else $error("fast erase strobe too short");
	a_erase_min: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		$fell(strobe_o) && st_r.op == nvw_pkg::OP_WRITE
		|-> $past(st_r.run) >= 20'(CYC_ERASE - 1))
		else $error("erase strobe too short");
	a_eo_time: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		$rose(select_in_a_n_o) && st_r.op == nvw_pkg::OP_ERASE
		|-> $past(st_r.run) >= 20'(CYC_ERASE - 1))
		else $error("erase-only ended too early");
	a_read_dir: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		$rose(strobe_o) && st_r.op == nvw_pkg::OP_READ |-> direction_line_o && !select_in_a_n_o)
		else $error("read strobe without direction high");
	a_no_drive_rd: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		data_oe_o |-> !direction_line_o && !select_in_b_n_o)
		else $error("bus driven outside write phase");
	a_strobe_dir: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		$rose(direction_line_o) |-> !strobe_o)
		else $error("direction rose with strobe high");
	a_erase_model: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		rsp_valid_o && st_r.op == nvw_pkg::OP_ERASE |-> rsp_data_o == 4'hF)
		else $error("erase-only answer not all ones");
	a_standby: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		cmd_ready_o |-> direction_line_o && !strobe_o && !data_oe_o)
		else $error("idle pins not at standby");
	a_sel_pair: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		select_in_a_n_o == select_in_b_n_o)
		else $error("selects differ");
	a_write_wait: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		$rose(direction_line_o) && st_r.op[0] && !select_in_a_n_o
		|-> $past(st_r.run) >= 20'(CYC_WRITE - 1))
		else $error("write phase too short");
	c_read: cover property (@(posedge ref_clk_i) rsp_valid_o && st_r.op == nvw_pkg::OP_READ);
	c_write: cover property (@(posedge ref_clk_i) rsp_valid_o && st_r.op == nvw_pkg::OP_WRITE);
	c_erase: cover property (@(posedge ref_clk_i) rsp_valid_o && st_r.op == nvw_pkg::OP_ERASE);
	c_fast: cover property (@(posedge ref_clk_i) rsp_valid_o && st_r.op == nvw_pkg::OP_FAST);
endmodule

// ---- testbench/nvw_mem_model.sv ----
// Purpose: behavioural model of the 64x4 non-volatile word memory
// Assumes: pins come straight from the host, no clock inside
// Notes: output delay parameter lets the bench try slow answers
`timescale 1ns/10ps
module nvw_mem_model #(
	parameter int OUT_DLY_NS = 0
) (
	input wire logic sel_a_n_i,
	input wire logic sel_b_n_i,
	input wire logic dir_i,
	input wire logic strobe_i,
	input wire logic [5:0] addr_i,
	input wire logic [3:0] bus_i,
	output wire logic [3:0] q_o,
	output wire logic oe_o
);
	logic [3:0] mem [64];
	logic [3:0] out_r = 4'h0;
	logic [5:0] wa_r = 6'h00;
	logic show_r = 1'b0;
	logic wr_r = 1'b0;
	wire logic sel = !sel_a_n_i && !sel_b_n_i;
	// a deselected part floats; the latched word stays for standby
	assign #(OUT_DLY_NS) oe_o = sel && show_r;
	assign #(OUT_DLY_NS) q_o = out_r;
	initial begin
		for (int i = 0; i < 64; i++) mem[i] = 4'h0;
	end
	// rising strobe latches a read word or erases to all ones
	always @(posedge strobe_i) begin
		if (sel && dir_i) out_r = mem[addr_i];
		if (sel && !dir_i) mem[wa_r] = 4'hF;
	end
	// falling strobe shows read data or takes write data off the bus
	always @(negedge strobe_i) begin
		if (sel && dir_i) show_r = 1'b1;
		if (sel && !dir_i) begin
			mem[wa_r] = bus_i;
			out_r = bus_i;
			wr_r = 1'b1;
		end
	end
	// falling direction opens an erase-write cycle
	always @(negedge dir_i) begin
		if (sel) begin
			wa_r = addr_i;
			show_r = 1'b0;
			wr_r = 1'b0;
		end
	end
	// rising direction ends writing; deselect-ended erase never gets here
	always @(posedge dir_i) begin
		if (sel && wr_r) show_r = 1'b1;
	end
endmodule

// ---- testbench/nonvolatile_word_memory_access_bench.sv ----
// Purpose: self-checking bench for the word memory host sequencer
// Assumes: erase and write counts shortened to 40 cycles
// Notes: reference array mirrors each word written or erased
`timescale 1ns/10ps
module nonvolatile_word_memory_access_bench;
	localparam int CE = 40;
	localparam int CW = 40;
	logic ref_clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic cmd_valid_i = 1'b0;
	logic [1:0] cmd_op_i = 2'h0;
	logic [5:0] cmd_addr_i = 6'h00;
	logic [3:0] cmd_data_i = 4'h0;
	logic cmd_ready_o, rsp_valid_o, sa_n, sb_n, dir, strobe, data_oe, mem_oe;
	logic [3:0] rsp_data_o, data_o, mem_q;
	logic [5:0] addr;
	logic flt_r = 1'b0;
	logic [3:0] ref_mem [64];
	int seed = 32'hfc6c;
	int err_count = 0;
	int check_count = 0;
	int cyc = 0;
	int hi_c = 0, hi_last = 0, sel_at = 0, dlo_c = 0, dlo_last = 0;
	logic ord_bad = 1'b0;
	// undriven bus toggles so a stale value cannot pass
	wire logic [3:0] bus = data_oe ? data_o : (mem_oe ? mem_q : {4{flt_r}});
	always #10 ref_clk_i = ~ref_clk_i;
	nvw_host #(.CYC_ERASE(CE), .CYC_WRITE(CW)) nvw_host_inst (.ref_clk_i(ref_clk_i),
		.rstn_i(rstn_i), .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i),
		.cmd_addr_i(cmd_addr_i), .cmd_data_i(cmd_data_i), .cmd_ready_o(cmd_ready_o),
		.rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .select_in_a_n_o(sa_n),
		.select_in_b_n_o(sb_n), .direction_line_o(dir), .strobe_o(strobe),
		.addr_o(addr), .data_i(bus), .data_o(data_o), .data_oe_o(data_oe));
	nvw_mem_model #(.OUT_DLY_NS(2000)) nvw_mem_model_inst (.sel_a_n_i(sa_n),
		.sel_b_n_i(sb_n), .dir_i(dir), .strobe_i(strobe), .addr_i(addr), .bus_i(bus),
		.q_o(mem_q), .oe_o(mem_oe));
	// pin timing monitor; hang guard counts a mismatch
	always @(posedge ref_clk_i) begin
		flt_r <= ~flt_r;
		cyc <= cyc + 1;
		hi_c <= strobe ? hi_c + 1 : 0;
		dlo_c <= (!dir && !strobe) ? dlo_c + 1 : 0;
		if ($fell(strobe)) hi_last <= hi_c;
		if ($rose(sa_n)) sel_at <= hi_c;
		if ($rose(dir)) begin
			dlo_last <= dlo_c;
			ord_bad <= strobe;
		end
		if (cyc == 60000) begin
			err_count++;
			print_verdict();
		end
	end
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one command, answer and pin timing against the reference
	task automatic op(input logic [1:0] o, input logic [5:0] a, input logic [3:0] d);
		logic [3:0] exp;
		int n;
		n = 0;
		exp = (o == nvw_pkg::OP_READ) ? ref_mem[a] : d;
		if (o == nvw_pkg::OP_ERASE) exp = nvw_pkg::ERASED_WORD;
		cmd_op_i <= o;
		cmd_addr_i <= a;
		cmd_data_i <= d;
		cmd_valid_i <= 1'b1;
		do @(posedge ref_clk_i); while (cmd_ready_o !== 1'b1);
		cmd_valid_i <= 1'b0;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (rsp_valid_o !== 1'b1 && n < 5000);
		cmp(32'(rsp_valid_o), 1);
		cmp(rsp_data_o, exp);
		if (o != nvw_pkg::OP_READ) ref_mem[a] = exp;
		repeat (2) @(posedge ref_clk_i);
		if (o == nvw_pkg::OP_WRITE) cmp(32'(hi_last >= CE), 1);
		if (o == nvw_pkg::OP_FAST) cmp(32'(hi_last >= nvw_pkg::CYC_FAST), 1);
		if (o[0]) cmp(32'(dlo_last >= CW), 1);
		if (o == nvw_pkg::OP_ERASE) cmp(32'(sel_at >= CE), 1);
		if (o != nvw_pkg::OP_READ) cmp(ord_bad, 0);
		$display("op %0d at %h done", o, a);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		logic [5:0] a;
		logic [3:0] d;
		repeat (20) @(posedge ref_clk_i);
		rstn_i <= 1'b1;
		@(posedge ref_clk_i);
		// random words, both ends of the address range first
		for (int i = 0; i < 6; i++) begin
			a = (i == 0) ? 6'h00 : (i == 1) ? 6'h3F : 6'($random(seed));
			d = 4'($random(seed));
			op(nvw_pkg::OP_WRITE, a, d);
			op(nvw_pkg::OP_READ, a, 4'h0);
		end
		// erase alone, read ones, then short reprogram and read twice
		d = 4'($random(seed));
		op(nvw_pkg::OP_ERASE, a, 4'h0);
		op(nvw_pkg::OP_READ, a, 4'h0);
		op(nvw_pkg::OP_FAST, a, d);
		op(nvw_pkg::OP_READ, a, 4'h0);
		op(nvw_pkg::OP_READ, a, 4'h0);
		print_verdict();
	end
endmodule
